// *** hw/aseq_pkg.sv ***
// Purpose: Shared constants and types of the ADC scan sequencer.
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz aclk.
// Notes:   Offsets are byte addresses.
package aseq_pkg;
  localparam int          ADDR_W     = 9;
  localparam logic [8:0]  OFS_CTRL   = 9'h000;
  localparam logic [8:0]  OFS_STAT   = 9'h004;
  localparam logic [8:0]  OFS_TIMER  = 9'h008;
  localparam logic [1:0]  REG_INSTR  = 2'h1;
  localparam logic [1:0]  REG_DATA   = 2'h2;
  localparam int          CTRL_START = 0;
  localparam int          CTRL_STOP  = 1;
  localparam int          CTRL_IRQEN = 2;
  localparam int          ST_AVAIL   = 0;
  localparam int          ST_OVF     = 1;
  localparam int          ST_TERR    = 2;
  localparam int          ST_IRAM    = 3;
  localparam int          ST_RUN     = 4;
  localparam int          INSTR_EN   = 3;
  localparam int          NCHAN      = 32;
  localparam int          CH_W       = 5;
  localparam int          INSTR_W    = 16;
  localparam int          RES_W      = 16;
  localparam int          TIMER_W    = 16;
  localparam logic [15:0] TIMER_RST  = 16'h0000;
  localparam logic [15:0] TIMER_CONT = 16'h0000;
  localparam logic [4:0]  CH_LAST    = 5'h1f;
  localparam int          TIMER_UNIT_US = 100;
  localparam int          CLK_MHZ    = 200;
  localparam int          TICK_CYCLES = TIMER_UNIT_US * CLK_MHZ;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    S_IDLE, S_WAIT, S_FETCH, S_LOAD, S_CONV, S_END
  } aseq_state_t;
endpackage

// *** hw/aseq_ram_if.sv ***
// Purpose: Port bundle between the sequencer and its memories.
// Assumes: One write and one registered read port.
// Notes:   Read data appear one cycle after raddr.
interface aseq_ram_if #(
  parameter int AW = 5,
  parameter int DW = 16
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// *** hw/aseq_ram.sv ***
// Purpose: Simple dual-port memory with registered read data.
// Assumes: Same clock on both ports.
// Notes:   Contents are not reset.
module aseq_ram #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  // Clock
  input wire logic aclk,
  // Ports
  aseq_ram_if.mem  p
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  always_ff @(posedge aclk) begin
    if (p.we) begin
      mem_q[p.waddr] <= p.wdata;
    end
    rd_q <= mem_q[p.raddr];
  end

  assign p.rdata = rd_q;
endmodule

// *** hw/aseq_top.sv ***
// Purpose: ADC scan sequencer with error detection, AXI4-Lite slave.
// Assumes: ADC handshake runs on aclk; adc_done pulses once per start.
// Notes:   Results go to a shadow bank, swapped at the end of a pass unless that pass overflows.
// Behaviour
// - On error, finish pass, halt, set flag
// - Timer mode: unacknowledged data raises overflow
// - Writing one to status bit 1 clears overflow
// - Timer mode: interval shorter than pass, timer error
// - Writing one to status bit 2 clears timer error
// - Start with no channel enabled: instruction error
// - Writing one to status bit 3 clears instruction error
// - Any error flag with interrupts enabled: irq
// - Continuous mode: no overflow, flag reads zero
// - Pass end sets data-available, one clears it
// - Timer in 100us units restarts passes
// - Enabled channels converted ascending, stored at end
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
module aseq_top #(
  parameter int PRESCALE = aseq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [8:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [8:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Converter
  output logic             adc_start,
  output logic [4:0]       adc_chan,
  output logic [15:0]      adc_cfg,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_result,
  // Interrupt request
  output logic             irq
);
  localparam int PW = $clog2(PRESCALE + 1);

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic mapped(input logic [8:0] a);
    return a == aseq_pkg::OFS_CTRL || a == aseq_pkg::OFS_STAT ||
           a == aseq_pkg::OFS_TIMER || a[8:7] == aseq_pkg::REG_INSTR ||
           a[8:7] == aseq_pkg::REG_DATA;
  endfunction

  aseq_ram_if #(.AW(5), .DW(16)) irom_if ();
  aseq_ram_if #(.AW(6), .DW(16)) dram_if ();
  aseq_ram #(.AW(5), .DW(16)) u_irom (.aclk(aclk), .p(irom_if.mem));
  aseq_ram #(.AW(6), .DW(16)) u_dram (.aclk(aclk), .p(dram_if.mem));

  // Bus state
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [8:0]  awa_q, awa_d, ra_q, ra_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
  logic [3:0]  ws_q, ws_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rpend_q, rpend_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        do_wr, ar_fire;
  logic [31:0] wm, wv, rd_mux;

  // Sequencer state
  aseq_pkg::aseq_state_t st_q, st_d;
  logic [4:0]  ch_q, ch_d;
  logic [31:0] en_q, en_d;
  logic [15:0] timer_q, timer_d, tcnt_q, tcnt_d, cfg_q, cfg_d;
  logic [PW-1:0] presc_q, presc_d;
  logic        bank_q, bank_d, terr_p_q, terr_p_d, irq_en_q, irq_en_d;
  logic        avail_q, avail_d, ovf_q, ovf_d, terr_q, terr_d;
  logic        iram_q, iram_d, irq_q, irq_d, start_q, start_d;
  logic [4:0]  chan_q, chan_d;
  logic        wr_ctrl, wr_stat, wr_timer, tmode, tick, hit, busy;
  logic        avail_set, ovf_set, terr_set, iram_set;
  logic [3:0]  clr;

  assign do_wr    = aw_have_q & w_have_q & ~bvalid_q;
  assign ar_fire  = arvalid & arready_q;
  assign wm       = lane_mask(ws_q);
  assign wv       = wd_q & wm;
  assign wr_ctrl  = do_wr && awa_q == aseq_pkg::OFS_CTRL;
  assign wr_stat  = do_wr && awa_q == aseq_pkg::OFS_STAT;
  assign wr_timer = do_wr && awa_q == aseq_pkg::OFS_TIMER;
  // Zero bits of a status write leave flags alone
  assign clr      = wr_stat ? wv[3:0] : 4'h0;
  assign tmode    = timer_q != aseq_pkg::TIMER_CONT;
  assign tick     = presc_q == PW'(PRESCALE - 1);
  assign hit      = tmode && tick && (tcnt_q + 16'h1) == timer_q;
  assign busy     = st_q != aseq_pkg::S_IDLE && st_q != aseq_pkg::S_WAIT;

  assign irom_if.we    = do_wr && awa_q[8:7] == aseq_pkg::REG_INSTR;
  assign irom_if.waddr = awa_q[6:2];
  assign irom_if.wdata = wd_q[15:0];
  assign irom_if.raddr = ch_q;
  assign dram_if.raddr = {bank_q, araddr[6:2]};
  assign dram_if.we    = st_q == aseq_pkg::S_CONV && adc_done;
  // Results land in the hidden bank until the pass completes
  assign dram_if.waddr = {~bank_q, ch_q};
  assign dram_if.wdata = adc_result;

  always_comb begin
    rd_mux = 32'h0;
    if (ra_q == aseq_pkg::OFS_CTRL) begin
      rd_mux[aseq_pkg::CTRL_IRQEN] = irq_en_q;
    end else if (ra_q == aseq_pkg::OFS_STAT) begin
      rd_mux[aseq_pkg::ST_AVAIL] = avail_q;
      rd_mux[aseq_pkg::ST_OVF]   = ovf_q & tmode;
      rd_mux[aseq_pkg::ST_TERR]  = terr_q;
      rd_mux[aseq_pkg::ST_IRAM]  = iram_q;
      rd_mux[aseq_pkg::ST_RUN]   = st_q != aseq_pkg::S_IDLE;
    end else if (ra_q == aseq_pkg::OFS_TIMER) begin
      rd_mux[15:0] = timer_q;
    end else if (ra_q[8:7] == aseq_pkg::REG_INSTR) begin
      rd_mux[aseq_pkg::INSTR_EN] = en_q[ra_q[6:2]];
    end else if (ra_q[8:7] == aseq_pkg::REG_DATA) begin
      rd_mux[15:0] = dram_if.rdata;
    end
  end

  always_comb begin
    aw_have_d = do_wr ? 1'b0 : aw_have_q | (awvalid & awready_q);
    w_have_d  = do_wr ? 1'b0 : w_have_q | (wvalid & wready_q);
    awa_d     = (awvalid & awready_q) ? awaddr : awa_q;
    wd_d      = (wvalid & wready_q) ? wdata : wd_q;
    ws_d      = (wvalid & wready_q) ? wstrb : ws_q;
    awready_d = ~aw_have_d;
    wready_d  = ~w_have_d;
    bvalid_d  = do_wr | (bvalid_q & ~bready);
    bresp_d   = bresp_q;
    if (do_wr) begin
      bresp_d = mapped(awa_q) ? aseq_pkg::RESP_OKAY : aseq_pkg::RESP_DECERR;
    end
    ra_d      = ar_fire ? araddr : ra_q;
    rpend_d   = ar_fire;
    rvalid_d  = rpend_q | (rvalid_q & ~rready);
    arready_d = ~rpend_d & ~rvalid_d;
    rdata_d   = rpend_q ? rd_mux : rdata_q;
    rresp_d   = rresp_q;
    if (rpend_q) begin
      rresp_d = mapped(ra_q) ? aseq_pkg::RESP_OKAY : aseq_pkg::RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awa_q     <= 9'h000;
      wd_q      <= 32'h0;
      ws_q      <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      ra_q      <= 9'h000;
      rpend_q   <= 1'b0;
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awa_q     <= awa_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      ra_q      <= ra_d;
      rpend_q   <= rpend_d;
      rvalid_q  <= rvalid_d;
      arready_q <= arready_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  always_comb begin
    st_d      = st_q;
    ch_d      = ch_q;
    bank_d    = bank_q;
    terr_p_d  = terr_p_q | (busy & hit);
    tcnt_d    = tick ? tcnt_q + 16'h1 : tcnt_q;
    presc_d   = tick ? '0 : presc_q + PW'(1);
    start_d   = 1'b0;
    chan_d    = chan_q;
    cfg_d     = cfg_q;
    avail_set = 1'b0;
    ovf_set   = 1'b0;
    terr_set  = 1'b0;
    iram_set  = 1'b0;
    en_d      = en_q;
    if (irom_if.we) begin
      en_d[awa_q[6:2]] = wd_q[aseq_pkg::INSTR_EN];
    end
    irq_en_d  = wr_ctrl ? (irq_en_q & ~wm[aseq_pkg::CTRL_IRQEN]) |
                wv[aseq_pkg::CTRL_IRQEN] : irq_en_q;
    timer_d   = wr_timer ? (timer_q & ~wm[15:0]) | wv[15:0] : timer_q;
    case (st_q)
      aseq_pkg::S_IDLE: begin
        // A halted sequencer waits for software to start it
        if (wr_ctrl && wv[aseq_pkg::CTRL_START]) begin
          if (en_q == 32'h0) begin
            iram_set = 1'b1;
          end else begin
            st_d     = aseq_pkg::S_FETCH;
            ch_d     = 5'h00;
            tcnt_d   = 16'h0;
            terr_p_d = 1'b0;
          end
        end
      end
      aseq_pkg::S_WAIT: begin
        if (hit || !tmode) begin
          st_d   = aseq_pkg::S_FETCH;
          ch_d   = 5'h00;
          tcnt_d = 16'h0;
        end
      end
      aseq_pkg::S_FETCH: begin
        if (en_q[ch_q]) begin
          st_d = aseq_pkg::S_LOAD;
        end else if (ch_q == aseq_pkg::CH_LAST) begin
          st_d = aseq_pkg::S_END;
        end else begin
          ch_d = ch_q + 5'h01;
        end
      end
      aseq_pkg::S_LOAD: begin
        start_d = 1'b1;
        chan_d  = ch_q;
        cfg_d   = irom_if.rdata;
        st_d    = aseq_pkg::S_CONV;
      end
      aseq_pkg::S_CONV: begin
        if (adc_done) begin
          if (ch_q == aseq_pkg::CH_LAST) begin
            st_d = aseq_pkg::S_END;
          end else begin
            ch_d = ch_q + 5'h01;
            st_d = aseq_pkg::S_FETCH;
          end
        end
      end
      aseq_pkg::S_END: begin
        // Fresh results but the last pass still unacknowledged
        ovf_set  = tmode & avail_q;
        terr_set = terr_p_q | hit;
        if (!ovf_set) begin
          bank_d    = ~bank_q;
          avail_set = 1'b1;
        end
        terr_p_d = 1'b0;
        if (ovf_set || terr_set) begin
          st_d = aseq_pkg::S_IDLE;
        end else begin
          st_d = tmode ? aseq_pkg::S_WAIT : aseq_pkg::S_FETCH;
          ch_d = 5'h00;
          if (!tmode) begin
            tcnt_d = 16'h0;
          end
        end
      end
      default: st_d = aseq_pkg::S_IDLE;
    endcase
    if (wr_ctrl && wv[aseq_pkg::CTRL_STOP]) begin
      st_d = aseq_pkg::S_IDLE;
    end
    // Set beats a simultaneous clear so no event is lost
    avail_d = avail_set | (avail_q & ~clr[0]);
    ovf_d   = ovf_set | (ovf_q & ~clr[1]);
    terr_d  = terr_set | (terr_q & ~clr[2]);
    iram_d  = iram_set | (iram_q & ~clr[3]);
    irq_d   = irq_en_q & (avail_q | (ovf_q & tmode) | terr_q | iram_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= aseq_pkg::S_IDLE;
      ch_q     <= 5'h00;
      bank_q   <= 1'b0;
      terr_p_q <= 1'b0;
      tcnt_q   <= 16'h0;
      presc_q  <= '0;
      start_q  <= 1'b0;
      chan_q   <= 5'h00;
      cfg_q    <= 16'h0;
      en_q     <= 32'h0;
      irq_en_q <= 1'b0;
      timer_q  <= aseq_pkg::TIMER_RST;
      avail_q  <= 1'b0;
      ovf_q    <= 1'b0;
      terr_q   <= 1'b0;
      iram_q   <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      ch_q     <= ch_d;
      bank_q   <= bank_d;
      terr_p_q <= terr_p_d;
      tcnt_q   <= tcnt_d;
      presc_q  <= presc_d;
      start_q  <= start_d;
      chan_q   <= chan_d;
      cfg_q    <= cfg_d;
      en_q     <= en_d;
      irq_en_q <= irq_en_d;
      timer_q  <= timer_d;
      avail_q  <= avail_d;
      ovf_q    <= ovf_d;
      terr_q   <= terr_d;
      iram_q   <= iram_d;
      irq_q    <= irq_d;
    end
  end

  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign adc_start = start_q;
  assign adc_chan  = chan_q;
  assign adc_cfg   = cfg_q;
  assign irq       = irq_q;

  property p_halt;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == aseq_pkg::S_END && (ovf_set || terr_set) && !wr_ctrl)
      |=> st_q == aseq_pkg::S_IDLE && (ovf_q || terr_q);
  endproperty
  a_halt: assert property (p_halt) else $error("no halt on error");

  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
    // Overflowing results are dropped, so the visible bank must not swap
    (st_q == aseq_pkg::S_END && tmode && avail_q) |=> ovf_q && $stable(bank_q);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");

  property p_ovf_clr;
    @(posedge aclk) disable iff (!aresetn)
    (clr[1] && !ovf_set) |=> !ovf_q;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("ovf not cleared");

  property p_terr;
    @(posedge aclk) disable iff (!aresetn)
    (busy && hit) |=> terr_p_q || terr_q;
  endproperty
  a_terr: assert property (p_terr) else $error("timer error missed");

  property p_terr_clr;
    @(posedge aclk) disable iff (!aresetn)
    (clr[2] && !terr_set) |=> !terr_q;
  endproperty
  a_terr_clr: assert property (p_terr_clr) else $error("terr stuck");

  property p_iram;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == aseq_pkg::S_IDLE && wr_ctrl && wv[aseq_pkg::CTRL_START] &&
     en_q == 32'h0) |=> iram_q && st_q == aseq_pkg::S_IDLE;
  endproperty
  a_iram: assert property (p_iram) else $error("iram error missed");

  property p_iram_clr;
    @(posedge aclk) disable iff (!aresetn)
    (clr[3] && !iram_set) |=> !iram_q;
  endproperty
  a_iram_clr: assert property (p_iram_clr) else $error("iram stuck");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    (irq_en_q && (terr_q || iram_q || (ovf_q && tmode))) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_cont;
    @(posedge aclk) disable iff (!aresetn)
    (timer_q == aseq_pkg::TIMER_CONT) |-> !ovf_set;
  endproperty
  a_cont: assert property (p_cont) else $error("ovf in continuous");

  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == aseq_pkg::S_WAIT && hit && !wr_ctrl)
      |=> st_q == aseq_pkg::S_FETCH && ch_q == 5'h00 && tcnt_q == 16'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_order;
    @(posedge aclk) disable iff (!aresetn)
    // A stop or an instruction write may legally land in the load cycle
    (adc_start && !$past(wr_ctrl && wv[aseq_pkg::CTRL_STOP]) &&
     !$past(irom_if.we)) |-> en_q[adc_chan] && st_q == aseq_pkg::S_CONV;
  endproperty
  a_order: assert property (p_order) else $error("bad channel");

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (terr_q && !clr[2]) |=> terr_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule

// *** bench/aseq_adc_model.sv ***
// Purpose: Behavioural converter on the far side of the sequencer.
// Assumes: One adc_done pulse per adc_start, after lat+1 idle cycles.
// Notes:   Logs every channel started, for the order checks.
module aseq_adc_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Converter handshake
  input  wire logic        adc_start,
  input  wire logic [4:0]  adc_chan,
  input  wire logic [15:0] adc_cfg,
  output logic             adc_done,
  output logic [15:0]      adc_result,
  // Answer latency in cycles
  input  wire logic [7:0]  lat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  chans[$];
  logic [15:0] cfgs[$];
  logic [7:0]  cnt_q;
  logic        busy_q;
  logic [15:0] val_q;
  // Result lines show garbage outside the done cycle
  always @(posedge aclk) begin
    adc_done   <= 1'b0;
    adc_result <= ~val_q;
    if (!aresetn) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
      val_q  <= 16'h0000;
    end else if (adc_start) begin
      chans.push_back(adc_chan);
      cfgs.push_back(adc_cfg);
      val_q  <= 16'h5a00 | {11'h000, adc_chan};
      cnt_q  <= lat;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 8'h00) begin
        adc_done   <= 1'b1;
        adc_result <= val_q;
        busy_q     <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench of the sequencer error handling.
// Assumes: PRESCALE shortened to 4 cycles per timer unit.
// Notes:   Register access only through AXI4-Lite tasks.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] CTRL = aseq_pkg::OFS_CTRL;
  localparam logic [8:0] STAT = aseq_pkg::OFS_STAT;
  localparam logic [8:0] TMR  = aseq_pkg::OFS_TIMER;
  localparam logic [1:0] OK   = aseq_pkg::RESP_OKAY;
  localparam logic [1:0] DEC  = aseq_pkg::RESP_DECERR;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        adc_start, adc_done, irq;
  logic [8:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [4:0]  adc_chan;
  logic [15:0] adc_cfg, adc_result;
  logic [7:0]  lat;
  int          err_total, comparisons;

  aseq_top #(.PRESCALE(4)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_cfg(adc_cfg),
    .adc_done(adc_done), .adc_result(adc_result), .irq(irq)
  );
  aseq_adc_model adc (
    .aclk(aclk), .aresetn(aresetn), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_cfg(adc_cfg), .adc_done(adc_done),
    .adc_result(adc_result), .lat(lat)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tmo;
    err_total++;
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is a register, so it is looked at mid-cycle and acted on
  task automatic axi_wr(input logic [8:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int         n;
    bit         ta, tw, b;
    logic [1:0] r;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) tmo();
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [8:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    bit t, v;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge aclk);
      t = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
      if (v) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) tmo();
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic wait_stat(input int b);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (n = 0; n < 400; n++) begin
      axi_rd(STAT, d, r);
      if (d[b] === 1'b1) break;
    end
    if (n == 400) tmo();
  endtask

  task automatic irq_chk(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic t_instr_err;
    axi_wr(CTRL, 32'h5, OK);
    wait_stat(3);
    rd_chk(STAT, 32'h8, OK);
    irq_chk(1'b1);
    axi_wr(STAT, 32'h7, OK);
    rd_chk(STAT, 32'h8, OK);
    axi_wr(STAT, 32'h8, OK);
    rd_chk(STAT, 32'h0, OK);
    irq_chk(1'b0);
    axi_wr(9'h1fc, 32'h1, DEC);
    rd_chk(9'h1fc, 32'h0, DEC);
  endtask

  task automatic t_cont;
    axi_wr(9'h088, 32'h8, OK);
    axi_wr(9'h0fc, 32'h8, OK);
    rd_chk(9'h088, 32'h8, OK);
    adc.chans.delete();
    adc.cfgs.delete();
    axi_wr(CTRL, 32'h1, OK);
    wait_stat(0);
    chk({27'h0, adc.chans[0]}, 32'h2);
    chk({16'h0, adc.cfgs[1]}, 32'h8);
    chk({27'h0, adc.chans[1]}, 32'h1f);
    rd_chk(9'h108, 32'h5a02, OK);
    rd_chk(9'h17c, 32'h5a1f, OK);
    repeat (200) @(posedge aclk);
    rd_chk(STAT, 32'h11, OK);
    axi_wr(CTRL, 32'h2, OK);
    axi_wr(STAT, 32'h1, OK);
    rd_chk(STAT, 32'h0, OK);
  endtask

  task automatic t_ovf;
    int k;
    axi_wr(TMR, 32'd100, OK);
    axi_wr(CTRL, 32'h1, OK);
    wait_stat(1);
    rd_chk(STAT, 32'h3, OK);
    k = adc.chans.size();
    repeat (800) @(posedge aclk);
    chk(32'(k), 32'(adc.chans.size()));
    axi_wr(TMR, 32'h0, OK);
    rd_chk(STAT, 32'h1, OK);
    axi_wr(TMR, 32'd100, OK);
    rd_chk(STAT, 32'h3, OK);
    axi_wr(STAT, 32'h2, OK);
    rd_chk(STAT, 32'h1, OK);
    axi_wr(STAT, 32'h1, OK);
    // Acknowledged within one interval, so the next pass stores cleanly
    axi_wr(CTRL, 32'h1, OK);
    wait_stat(0);
    rd_chk(9'h108, 32'h5a02, OK);
    axi_wr(STAT, 32'h1, OK);
    wait_stat(0);
    rd_chk(STAT, 32'h11, OK);
    axi_wr(CTRL, 32'h2, OK);
    axi_wr(STAT, 32'h1, OK);
  endtask

  // A one-unit interval is far shorter than a slow two-channel pass
  task automatic t_terr;
    lat <= 8'd20;
    axi_wr(TMR, 32'h1, OK);
    axi_wr(CTRL, 32'h5, OK);
    wait_stat(2);
    rd_chk(STAT, 32'h5, OK);
    irq_chk(1'b1);
    axi_wr(STAT, 32'h4, OK);
    rd_chk(STAT, 32'h1, OK);
    axi_wr(STAT, 32'h1, OK);
    axi_wr(TMR, 32'h0, OK);
    axi_wr(CTRL, 32'h1, OK);
    rd_chk(STAT, 32'h10, OK);
    axi_wr(CTRL, 32'h2, OK);
  endtask

  initial begin
    err_total   = 0;
    comparisons = 0;
    aresetn     = 1'b0;
    awaddr      = 9'h000;
    araddr      = 9'h000;
    wdata       = 32'h0;
    awvalid     = 1'b0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    lat         = 8'h3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_instr_err();
    t_cont();
    t_ovf();
    t_terr();
    end_of_test();
  end
endmodule
